// ==== dv/tb_rstc_top.sv ====
`timescale 1ns/1ps
`include "rstc_defs.svh"
`define CHK(a, b) chk((a) === (b))
module tb_rstc_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        pq = 1'b0;
    logic        sync = 1'b0;
    logic        pkt = 1'b0;
    logic        csv = 1'b0;
    logic        car = 1'b0;
    logic [7:0]  rdata;
    logic [2:0]  state;
    logic        cal;
    logic [25:0] carrier;
    logic [7:0]  ifw;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          n;

    always #25 clk = ~clk;

    rstc_top #(.CAL_START_CYC(16'd40), .TX_IDLE_CAL(16'd30),
        .RX_IDLE_CAL(16'd32), .MANUAL_CAL(16'd50), .RX_TIME_UNIT(16'd16))
    dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .SYNC_FOUND_IN(sync),
        .PREAMBLE_QUAL_IN(pq), .CS_VALID_IN(csv), .CARRIER_IN(car),
        .PKT_DONE_IN(pkt), .RDATA_OUT(rdata), .STATE_OUT(state),
        .CAL_ACTIVE_OUT(cal), .CARRIER_WORD_OUT(carrier),
        .IF_WORD_OUT(ifw));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input bit ok);
        check_count++;
        if (!ok)
            $display("BAD %0t value mismatch", $time);
        if (!ok)
            mismatches++;
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e);
        @(posedge clk);
        #1;
        `CHK(rdata, 8'h00);
    endtask

    // The count starts in the cycle after the strobe, so cycle one is 4.
    task automatic go(input logic [7:0] c, input logic [2:0] t, input int e);
        wr8(`RSTC_ADDR_CMD, c);
        #1;
        n = 1;
        while (state !== t && n < 30000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n == e);
    endtask

    task automatic wait_state(input int k, input logic [2:0] e);
        repeat (k) @(posedge clk);
        #1;
        `CHK(state, e);
    endtask

    // Called in the cycle after the strobe of a calibrating move to idle.
    task automatic cal_run(input int e);
        #1;
        `CHK(cal, 1'b1);
        wait_state(e - 2, 3'd4);
        wait_state(1, 3'd0);
        `CHK(cal, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd8(`RSTC_ADDR_STATUS, 8'h00);
        rd8(8'h0b, 8'h00);
        wr8(`RSTC_ADDR_BASE_HIGH, 8'h12);
        wr8(`RSTC_ADDR_BASE_MID, 8'h34);
        wr8(`RSTC_ADDR_BASE_LOW, 8'h56);
        wr8(`RSTC_ADDR_SLOT, 8'h03);
        wr8(`RSTC_ADDR_MDM_ZERO, 8'h10);
        wr8(`RSTC_ADDR_MDM_ONE, 8'h02);
        wr8(`RSTC_ADDR_SYNTH_ONE, 8'h2a);
        repeat (3) @(posedge clk);
        #1;
        `CHK(carrier, 26'h123456 * 4 + ((26'd3 * 26'd272) << 2));
        `CHK(ifw, 8'h2a);
        wr8(`RSTC_ADDR_CMD, 8'h10);
        cal_run(50);
        $display("test regs done");
    endtask

    task automatic t_moves;
        go(8'h01, 3'd1, 1953);
        rd8(`RSTC_ADDR_STATUS, 8'h01);
        go(8'h08, 3'd0, 2);
        go(8'h02, 3'd2, 1954);
        go(8'h01, 3'd1, 802);
        go(8'h02, 3'd2, 782);
        go(8'h01, 3'd1, 802);
        go(8'h08, 3'd0, 2);
        $display("test moves done");
    endtask

    task automatic t_cal;
        wr8(`RSTC_ADDR_SM_ONE, 8'h01);
        go(8'h01, 3'd1, 40);
        wr8(`RSTC_ADDR_SM_ONE, 8'h02);
        go(8'h08, 3'd0, 2);
        go(8'h02, 3'd2, 1954);
        @(posedge clk);
        pkt <= 1'b1;
        @(posedge clk);
        pkt <= 1'b0;
        cal_run(50);
        // Only the fourth automatic stop in a row calibrates.
        wr8(`RSTC_ADDR_SM_ONE, 8'h03);
        for (int i = 1; i <= 4; i++)
        begin
            go(8'h01, 3'd1, 1953);
            wait_state(17, 3'd4);
            `CHK(cal, i == 4);
            if (i == 4)
                wait_state(30, 3'd4);
            wait_state(1, 3'd0);
        end
        $display("test cal done");
    endtask

    // Destination synth-on must be overridden by a timeout termination.
    task automatic t_timeout;
        wr8(`RSTC_ADDR_SM_ONE, 8'h04);
        wr8(`RSTC_ADDR_SM_TWO, 8'h00);
        go(8'h01, 3'd1, 1953);
        wait_state(16, 3'd1);
        wait_state(2, 3'd0);
        wr8(`RSTC_ADDR_SM_TWO, 8'h08);
        pq <= 1'b1;
        go(8'h01, 3'd1, 1953);
        wait_state(40, 3'd1);
        go(8'h08, 3'd0, 2);
        pq <= 1'b0;
        wr8(`RSTC_ADDR_SM_TWO, 8'h00);
        go(8'h01, 3'd1, 1953);
        @(posedge clk);
        sync <= 1'b1;
        @(posedge clk);
        sync <= 1'b0;
        wait_state(40, 3'd1);
        @(posedge clk);
        pkt <= 1'b1;
        @(posedge clk);
        pkt <= 1'b0;
        wait_state(780, 3'd4);
        wait_state(1, 3'd3);
        go(8'h08, 3'd0, 2);
        $display("test timeout done");
    endtask

    task automatic t_sense;
        wr8(`RSTC_ADDR_SM_ONE, 8'h0c);
        wr8(`RSTC_ADDR_SM_TWO, 8'h37);
        go(8'h01, 3'd1, 1953);
        @(posedge clk);
        csv <= 1'b1;
        @(posedge clk);
        csv <= 1'b0;
        wait_state(2, 3'd1);
        repeat (700) @(posedge clk);
        csv <= 1'b1;
        car <= 1'b1;
        @(posedge clk);
        car <= 1'b0;
        @(posedge clk);
        csv <= 1'b0;
        wait_state(2, 3'd1);
        // A received packet restarts receive and re-arms the abort.
        wr8(`RSTC_ADDR_SM_TWO, 8'h17);
        pkt <= 1'b1;
        @(posedge clk);
        pkt <= 1'b0;
        csv <= 1'b1;
        @(posedge clk);
        csv <= 1'b0;
        wait_state(1, 3'd0);
        $display("test sense done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_moves();
        t_cal();
        t_timeout();
        t_sense();
        results();
    end
endmodule // tb_rstc_top

// ==== inc/rstc_defs.svh ====
// What this block does
// - Idle to receive, no calibration: 1953 cycles.
// - Idle to active with calibration: 20768 cycles.
// - Idle to transmit or synth-on: 1954 cycles.
// - Turnaround 782 cycles, transmit-to-receive plus quarter symbol.
// - Transmit to idle: quarter symbol, calibration adds 18815.
// - Receive to idle: 2 cycles, or 18817 calibrating.
// - Manual calibration completes after 19098 cycles.
// - Receive timer starts on receive entry, programmable.
// - On expiry stay only if sync seen or qualifier holds.
// - Abort receive when first carrier sample fails.
// - Keyed modulation: no-carrier valid after eight symbols.
// - Abort or timeout termination always returns to idle.
// - Base carrier word is 24 bits in three bytes.
// - Eight-bit slot number scales spacing onto base.
// - Carrier word combines base, slot, mantissa and exponent.
// - Intermediate word is the programmed setting, registered unchanged.
// - Force-idle strobe skips automatic calibration.
`ifndef RSTC_DEFS_SVH
`define RSTC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RSTC_ADDR_CMD        8'h00
`define RSTC_ADDR_SM_ONE     8'h01
`define RSTC_ADDR_SM_TWO     8'h02
`define RSTC_ADDR_MDM_ZERO   8'h03
`define RSTC_ADDR_MDM_ONE    8'h04
`define RSTC_ADDR_BASE_HIGH  8'h05
`define RSTC_ADDR_BASE_MID   8'h06
`define RSTC_ADDR_BASE_LOW   8'h07
`define RSTC_ADDR_SLOT       8'h08
`define RSTC_ADDR_SYNTH_ONE  8'h09
`define RSTC_ADDR_STATUS     8'h0a

// ----------------------------------------------------------------
// Command bits
// ----------------------------------------------------------------
`define RSTC_CMD_RX          0
`define RSTC_CMD_TX          1
`define RSTC_CMD_FSTX        2
`define RSTC_CMD_IDLE        3
`define RSTC_CMD_CAL         4

// ----------------------------------------------------------------
// Calibration modes and timeout code
// ----------------------------------------------------------------
`define RSTC_CAL_ON_START    2'h1
`define RSTC_CAL_ON_STOP     2'h2
`define RSTC_CAL_FOURTH      2'h3
`define RSTC_RX_TIME_OFF     3'h7

// ----------------------------------------------------------------
// Transition counts in system clock cycles
// ----------------------------------------------------------------
`define RSTC_IDLE_RX_CYC     16'h07a1
`define RSTC_IDLE_TX_CYC     16'h07a2
`define RSTC_TURN_CYC        16'h030e
`define RSTC_RX_IDLE_CYC     16'h0002
`define RSTC_ASK_SYMBOLS     8
`define RSTC_CLK_HZ          20000000
`define RSTC_SYMBOL_HZ       250000

`endif

// ==== inc/rstc_intermediate_tone_word.sv ====
`timescale 1ns/1ps
interface rstc_intermediate_tone_word;
    logic [23:0] base_word;
    logic [7:0]  slot;
    logic [7:0]  mant;
    logic [1:0]  expo;
    logic [7:0]  if_set;
    logic [25:0] carrier;
    logic [7:0]  if_word;

    modport ctrl (output base_word, slot, mant, expo, if_set,
                  input  carrier, if_word);
    modport calc (input  base_word, slot, mant, expo, if_set,
                  output carrier, if_word);
endinterface

// ==== inc/rstc_pkg.sv ====
package rstc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_TX,
        ST_SYNTH_ON,
        ST_SETTLE
    } rstc_state_type;

    typedef struct packed {
        rstc_state_type state;
        rstc_state_type target;
        logic [15:0]    cnt;
        logic           cal_active;
        logic [15:0]    rx_timer;
        logic           timer_run;
        logic           sync_seen;
        logic           cs_done;
        logic [15:0]    rx_age;
        logic [1:0]     cal_every;
        logic [1:0]     auto_cal;
        logic [1:0]     rxoff;
        logic [2:0]     rx_time;
        logic           qual;
        logic           cs_en;
        logic           ask;
        logic [7:0]     mant;
        logic [1:0]     expo;
        logic [7:0]     base_hi;
        logic [7:0]     base_mid;
        logic [7:0]     base_lo;
        logic [7:0]     slot;
        logic [7:0]     if_set;
        logic [7:0]     rdata;
    } rstc_ctrl_type;

    typedef struct packed {
        logic [25:0] carrier;
        logic [7:0]  if_word;
    } rstc_base_carrier_word_type;

endpackage

// ==== src/rstc_base_carrier_word.sv ====
`timescale 1ns/1ps
module rstc_base_carrier_word
(
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    rstc_intermediate_tone_word.calc   fq
);
    rstc_pkg::rstc_base_carrier_word_type st;
    rstc_pkg::rstc_base_carrier_word_type next_st;
    logic [16:0]             prod;

    // ----------------------------------------------------------------
    // Word arithmetic
    // ----------------------------------------------------------------
    // The carrier word keeps two fraction bits so that an exponent
    // below two loses no spacing resolution.
    always_comb
    begin
        prod = 17'(fq.slot * (9'h100 + {1'b0, fq.mant}));
        next_st.carrier = 26'({fq.base_word, 2'b00})
                        + 26'({3'h0, prod} << fq.expo);
        next_st.if_word = fq.if_set;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            st <= '0;
        else
            st <= next_st;
    end

    assign fq.carrier = st.carrier;
    assign fq.if_word = st.if_word;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_carrier_sum: assert property (@(posedge clk_in) disable iff (rst_in)
        ##1 (fq.carrier == 26'({$past(fq.base_word), 2'b00})
            + 26'(26'($past(fq.slot)) * (26'h100 + 26'($past(fq.mant)))
            * (26'h1 << $past(fq.expo)))))
        else $error("carrier word mismatch");
    a_if_word: assert property (@(posedge clk_in) disable iff (rst_in)
        ##1 (fq.if_word == $past(fq.if_set)))
        else $error("intermediate word mismatch");
endmodule // rstc_base_carrier_word

// ==== src/rstc_top.sv ====
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "rstc_defs.svh"
module rstc_top
#(
    parameter logic [15:0] CAL_START_CYC = 16'd20768,
    parameter logic [15:0] TX_IDLE_CAL   = 16'd18815,
    parameter logic [15:0] RX_IDLE_CAL   = 16'd18817,
    parameter logic [15:0] MANUAL_CAL    = 16'd19098,
    parameter logic [15:0] RX_TIME_UNIT  = 16'h0400
)
(
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    input  wire logic        SYNC_FOUND_IN,
    input  wire logic        PREAMBLE_QUAL_IN,
    input  wire logic        CS_VALID_IN,
    input  wire logic        CARRIER_IN,
    input  wire logic        PKT_DONE_IN,
    output logic [7:0]       RDATA_OUT,
    output logic [2:0]       STATE_OUT,
    output logic             CAL_ACTIVE_OUT,
    output logic [25:0]      CARRIER_WORD_OUT,
    output logic [7:0]       IF_WORD_OUT
);
    localparam int SYM_CYC = `RSTC_CLK_HZ / `RSTC_SYMBOL_HZ;
    localparam logic [15:0] QSYM_CYC = 16'((SYM_CYC + 3) / 4);
    localparam logic [15:0] ASK_WIN =
        16'(`RSTC_ASK_SYMBOLS * SYM_CYC);

    rstc_pkg::rstc_ctrl_type st;
    rstc_pkg::rstc_ctrl_type next_st;
    rstc_intermediate_tone_word             fq ();

    logic                    cmd_wr;
    logic [4:0]              cmd;
    logic                    go;
    rstc_pkg::rstc_state_type go_tgt;
    logic [15:0]             go_len;
    logic                    go_cal;
    logic                    rx_start;
    logic                    want_cal;
    logic                    cs_fail;
    logic                    to_fail;
    logic                    to_stay;

    // ----------------------------------------------------------------
    // Control state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st  = st;
        cmd_wr   = WR_IN && (ADDR_IN == `RSTC_ADDR_CMD);
        cmd      = cmd_wr ? WDATA_IN[4:0] : 5'h00;
        go       = 1'b0;
        go_tgt   = rstc_pkg::ST_IDLE;
        go_len   = `RSTC_RX_IDLE_CYC;
        go_cal   = 1'b0;
        rx_start = 1'b0;
        want_cal = (st.auto_cal == `RSTC_CAL_ON_STOP)
                || (st.auto_cal == `RSTC_CAL_FOURTH
                    && st.cal_every == 2'h3);
        // Keyed modulation can look carrier-less between one-symbols,
        // so no-carrier samples are ignored until the window passes.
        cs_fail = st.cs_en && !st.cs_done && CS_VALID_IN && !CARRIER_IN
               && (!st.ask || st.rx_age >= ASK_WIN);
        to_stay = st.sync_seen
               || (st.qual && PREAMBLE_QUAL_IN);
        to_fail = st.timer_run && st.rx_timer == 16'h0 && !to_stay;

        if (WR_IN)
        begin
            case (ADDR_IN)
                `RSTC_ADDR_SM_ONE:
                begin
                    next_st.auto_cal = WDATA_IN[1:0];
                    next_st.rxoff    = WDATA_IN[3:2];
                end
                `RSTC_ADDR_SM_TWO:
                begin
                    next_st.rx_time = WDATA_IN[2:0];
                    next_st.qual    = WDATA_IN[3];
                    next_st.cs_en   = WDATA_IN[4];
                    next_st.ask     = WDATA_IN[5];
                end
                `RSTC_ADDR_MDM_ZERO:  next_st.mant     = WDATA_IN;
                `RSTC_ADDR_MDM_ONE:   next_st.expo     = WDATA_IN[1:0];
                `RSTC_ADDR_BASE_HIGH: next_st.base_hi  = WDATA_IN;
                `RSTC_ADDR_BASE_MID:  next_st.base_mid = WDATA_IN;
                `RSTC_ADDR_BASE_LOW:  next_st.base_lo  = WDATA_IN;
                `RSTC_ADDR_SLOT:      next_st.slot     = WDATA_IN;
                `RSTC_ADDR_SYNTH_ONE: next_st.if_set   = WDATA_IN;
                default: ;
            endcase
        end

        // Receive bookkeeping runs every cycle while receiving.
        if (st.state == rstc_pkg::ST_RX)
        begin
            if (st.rx_age != 16'hffff)
                next_st.rx_age = st.rx_age + 16'h1;
            if (st.timer_run)
            begin
                if (st.rx_timer == 16'h0)
                    next_st.timer_run = 1'b0;
                else
                    next_st.rx_timer = st.rx_timer - 16'h1;
            end
        end

        case (st.state)
            rstc_pkg::ST_IDLE:
            begin
                go = cmd[`RSTC_CMD_CAL] || cmd[`RSTC_CMD_RX]
                  || cmd[`RSTC_CMD_TX] || cmd[`RSTC_CMD_FSTX];
                if (cmd[`RSTC_CMD_IDLE])
                    go = 1'b0;
                else if (cmd[`RSTC_CMD_CAL])
                begin
                    go_tgt = rstc_pkg::ST_IDLE;
                    go_len = MANUAL_CAL;
                    go_cal = 1'b1;
                end
                else
                begin
                    go_cal = st.auto_cal == `RSTC_CAL_ON_START;
                    if (cmd[`RSTC_CMD_RX])
                        go_tgt = rstc_pkg::ST_RX;
                    else if (cmd[`RSTC_CMD_TX])
                        go_tgt = rstc_pkg::ST_TX;
                    else
                        go_tgt = rstc_pkg::ST_SYNTH_ON;
                    if (go_cal)
                        go_len = CAL_START_CYC;
                    else if (cmd[`RSTC_CMD_RX])
                        go_len = `RSTC_IDLE_RX_CYC;
                    else
                        go_len = `RSTC_IDLE_TX_CYC;
                end
            end
            rstc_pkg::ST_RX:
            begin
                go = 1'b1;
                if (cmd[`RSTC_CMD_IDLE])
                    go_len = `RSTC_RX_IDLE_CYC;
                else if (cmd[`RSTC_CMD_TX] || cmd[`RSTC_CMD_FSTX])
                begin
                    go_tgt = cmd[`RSTC_CMD_TX] ? rstc_pkg::ST_TX
                                               : rstc_pkg::ST_SYNTH_ON;
                    go_len = `RSTC_TURN_CYC;
                end
                else if (cs_fail || to_fail
                         || (PKT_DONE_IN && st.rxoff == 2'h0))
                begin
                    // Abort and failed timeout always end in idle.
                    go_cal = want_cal;
                    go_len = want_cal ? RX_IDLE_CAL
                                      : `RSTC_RX_IDLE_CYC;
                end
                else if (PKT_DONE_IN && st.rxoff != 2'h3)
                begin
                    go_tgt = st.rxoff == 2'h1 ? rstc_pkg::ST_SYNTH_ON
                                              : rstc_pkg::ST_TX;
                    go_len = `RSTC_TURN_CYC;
                end
                else
                begin
                    go       = 1'b0;
                    rx_start = PKT_DONE_IN;
                end
            end
            rstc_pkg::ST_TX:
            begin
                go = 1'b1;
                if (cmd[`RSTC_CMD_IDLE])
                    go_len = QSYM_CYC;
                else if (cmd[`RSTC_CMD_RX])
                begin
                    go_tgt = rstc_pkg::ST_RX;
                    go_len = `RSTC_TURN_CYC + QSYM_CYC;
                end
                else if (PKT_DONE_IN)
                begin
                    go_cal = want_cal;
                    go_len = want_cal ? TX_IDLE_CAL + QSYM_CYC
                                      : QSYM_CYC;
                end
                else
                    go = 1'b0;
            end
            rstc_pkg::ST_SYNTH_ON:
            begin
                go = 1'b1;
                if (cmd[`RSTC_CMD_IDLE])
                    go_len = `RSTC_RX_IDLE_CYC;
                else if (cmd[`RSTC_CMD_TX] || cmd[`RSTC_CMD_RX])
                begin
                    go_tgt = cmd[`RSTC_CMD_TX] ? rstc_pkg::ST_TX
                                               : rstc_pkg::ST_RX;
                    go_len = `RSTC_TURN_CYC;
                end
                else
                    go = 1'b0;
            end
            rstc_pkg::ST_SETTLE:
            begin
                if (cmd[`RSTC_CMD_IDLE] && st.target != rstc_pkg::ST_IDLE)
                    go = 1'b1;
                else if (st.cnt == 16'h0)
                begin
                    next_st.state      = st.target;
                    next_st.cal_active = 1'b0;
                    rx_start = st.target == rstc_pkg::ST_RX;
                end
                else
                    next_st.cnt = st.cnt - 16'h1;
            end
            default: next_st.state = rstc_pkg::ST_IDLE;
        endcase

        if (go)
        begin
            // A load of count minus two shows the new state exactly
            // that many cycles after the strobe cycle.
            next_st.state      = rstc_pkg::ST_SETTLE;
            next_st.target     = go_tgt;
            next_st.cnt        = go_len - 16'h2;
            next_st.cal_active = go_cal;
            if (st.auto_cal == `RSTC_CAL_FOURTH && go_tgt == rstc_pkg::ST_IDLE
                && !cmd[`RSTC_CMD_IDLE] && !cmd[`RSTC_CMD_CAL])
                next_st.cal_every = st.cal_every + 2'h1;
        end

        if (rx_start)
        begin
            next_st.rx_age    = 16'h0;
            next_st.cs_done   = 1'b0;
            next_st.sync_seen = 1'b0;
            next_st.timer_run = st.rx_time != `RSTC_RX_TIME_OFF;
            next_st.rx_timer  = 16'(({13'h0, st.rx_time} + 16'h1)
                                    * RX_TIME_UNIT);
        end
        // A sample or sync word in the restart cycle is kept: set wins.
        if (CS_VALID_IN && st.state == rstc_pkg::ST_RX
            && (!st.ask || st.rx_age >= ASK_WIN))
            next_st.cs_done = 1'b1;
        if (SYNC_FOUND_IN && (st.state == rstc_pkg::ST_RX || rx_start))
            next_st.sync_seen = 1'b1;

        next_st.rdata = 8'h00;
        if (RD_IN)
        begin
            case (ADDR_IN)
                `RSTC_ADDR_SM_ONE:   next_st.rdata = {4'h0, st.rxoff, st.auto_cal};
                `RSTC_ADDR_SM_TWO:   next_st.rdata = {2'h0, st.ask, st.cs_en,
                                                     st.qual, st.rx_time};
                `RSTC_ADDR_MDM_ZERO: next_st.rdata = st.mant;
                `RSTC_ADDR_MDM_ONE:  next_st.rdata = {6'h00, st.expo};
                `RSTC_ADDR_BASE_HIGH: next_st.rdata = st.base_hi;
                `RSTC_ADDR_BASE_MID: next_st.rdata = st.base_mid;
                `RSTC_ADDR_BASE_LOW: next_st.rdata = st.base_lo;
                `RSTC_ADDR_SLOT:     next_st.rdata = st.slot;
                `RSTC_ADDR_SYNTH_ONE: next_st.rdata = st.if_set;
                `RSTC_ADDR_STATUS:   next_st.rdata = {3'h0, st.cal_active,
                                                     st.sync_seen, st.state};
                default:             next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            st <= '0;
        else
            st <= next_st;
    end

    // ----------------------------------------------------------------
    // Frequency words
    // ----------------------------------------------------------------
    assign fq.base_word = {st.base_hi, st.base_mid, st.base_lo};
    assign fq.slot      = st.slot;
    assign fq.mant      = st.mant;
    assign fq.expo      = st.expo;
    assign fq.if_set    = st.if_set;

    rstc_base_carrier_word u_base_carrier_word
    (
        .clk_in (CORE_CLK_IN),
        .rst_in (RST_IN),
        .fq     (fq.calc)
    );

    assign RDATA_OUT        = st.rdata;
    assign STATE_OUT        = st.state;
    assign CAL_ACTIVE_OUT   = st.cal_active;
    assign CARRIER_WORD_OUT = fq.carrier;
    assign IF_WORD_OUT      = fq.if_word;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    a_idle_rx_plain: assert property (
        (st.state == rstc_pkg::ST_IDLE && cmd == 5'h01 && st.auto_cal != 2'h1)
        |=> (st.cnt == 16'd1951 && st.target == rstc_pkg::ST_RX))
        else $error("idle to receive count wrong");
    a_idle_cal_start: assert property (
        (st.state == rstc_pkg::ST_IDLE && st.auto_cal == 2'h1
         && (cmd == 5'h01 || cmd == 5'h02 || cmd == 5'h04))
        |=> (st.cnt == CAL_START_CYC - 16'h2 && st.cal_active))
        else $error("calibrating start count wrong");
    a_idle_tx_plain: assert property (
        (st.state == rstc_pkg::ST_IDLE && cmd == 5'h02 && st.auto_cal != 2'h1)
        |=> (st.cnt == 16'd1952 && st.target == rstc_pkg::ST_TX))
        else $error("idle to transmit count wrong");
    a_turn_rx_tx: assert property (
        (st.state == rstc_pkg::ST_RX && cmd == 5'h02)
        |=> (st.cnt == 16'd780 && st.target == rstc_pkg::ST_TX))
        else $error("turnaround count wrong");
    a_rx_force_idle: assert property (
        (st.state == rstc_pkg::ST_RX && cmd[3])
        |-> ##2 (st.state == rstc_pkg::ST_IDLE && !st.cal_active))
        else $error("receive force idle not two cycles");
    a_manual_cal: assert property (
        (st.state == rstc_pkg::ST_IDLE && cmd == 5'h10)
        |=> (st.cnt == MANUAL_CAL - 16'h2 && st.cal_active))
        else $error("manual calibration count wrong");
    a_timeout_idle: assert property (
        (st.state == rstc_pkg::ST_RX && to_fail && cmd == 5'h00 && !cs_fail)
        |=> (st.state == rstc_pkg::ST_SETTLE
             && st.target == rstc_pkg::ST_IDLE))
        else $error("failed timeout did not head for idle");
    a_sync_stays: assert property (
        (st.state == rstc_pkg::ST_RX && st.timer_run && st.rx_timer == 16'h0
         && st.sync_seen && cmd == 5'h00 && !cs_fail && !PKT_DONE_IN)
        |=> (st.state == rstc_pkg::ST_RX && !st.timer_run))
        else $error("qualified receive left");
    a_cs_abort: assert property (
        (st.state == rstc_pkg::ST_RX && cs_fail && cmd == 5'h00)
        |=> (st.target == rstc_pkg::ST_IDLE))
        else $error("carrier abort did not head for idle");
    a_settle_hold: assert property (
        (st.state == rstc_pkg::ST_SETTLE && st.cnt != 16'h0 && cmd == 5'h00)
        |=> (st.state == rstc_pkg::ST_SETTLE
             && st.cnt == $past(st.cnt) - 16'h1))
        else $error("state shown before count elapsed");
    a_rx_timer_load: assert property (
        (st.state == rstc_pkg::ST_SETTLE && st.cnt == 16'h0
         && st.target == rstc_pkg::ST_RX && st.rx_time != 3'h7 && cmd == 5'h00)
        |=> (st.state == rstc_pkg::ST_RX && st.timer_run))
        else $error("receive timer not started");

    c_enter_rx: cover property (
        st.state == rstc_pkg::ST_SETTLE ##1 st.state == rstc_pkg::ST_RX);
    c_cs_abort: cover property (st.state == rstc_pkg::ST_RX && cs_fail);
    c_turnaround: cover property (
        st.state == rstc_pkg::ST_TX && cmd == 5'h01);
    c_manual_cal: cover property (st.cal_active ##1 !st.cal_active);
endmodule // rstc_top
